/* File: ams_consts.svh */
// Constants for the asynchronous memory phase sequencer
`ifndef AMS_CONSTS_SVH
`define AMS_CONSTS_SVH

// System clock period in ns
`define AMS_CLK_PERIOD_NS 8
// Periods from wait deassertion at the pin to strobe rise
`define AMS_RELEASE_CYC 4
// Input flop plus state register between the wait pin and the strobe pin
`define AMS_RELEASE_PIPE 2
// Periods per counted external wait unit
`define AMS_WAIT_UNIT_CYC 16
// Idle select value, and reset values of the address, bank and data pins
`define AMS_CS_IDLE 4'hf
`define AMS_ADDR_RST 21'h000000
`define AMS_BANK_RST 2'h0
`define AMS_DATA_RST 16'h0000

`endif

/* File: ams_pkg.sv */
// Types shared by the asynchronous memory phase sequencer
package ams_pkg;

    typedef enum logic [2:0] {
        AMS_IDLE,
        AMS_SETUP,
        AMS_STROBE,
        AMS_EXTEND,
        AMS_RELEASE,
        AMS_HOLD,
        AMS_TURN
    } ams_state_t;

    // Timing settings, counts in system clock periods except the wait limit, which is in wait units
    typedef struct packed {
        logic select_strobe;
        logic extended_wait_enable;
        logic [1:0] turnaround_cycles;
        logic [3:0] read_setup_cycles;
        logic [5:0] read_strobe_cycles;
        logic [2:0] read_hold_cycles;
        logic [3:0] write_setup_cycles;
        logic [5:0] write_strobe_cycles;
        logic [2:0] write_hold_cycles;
        logic [7:0] max_wait_limit;
    } ams_cfg_t;

    typedef struct packed {
        logic write;
        logic [1:0] chip;
        logic [1:0] bank;
        logic [20:0] addr;
        logic [15:0] wdata;
    } ams_req_t;

    typedef struct packed {
        logic write;
        logic timeout;
        logic [15:0] rdata;
    } ams_rsp_t;

endpackage

/* File: ams_phase_cnt.sv */
// Down counter that times every phase of an access
`timescale 1ns/1ps
module ams_phase_cnt (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Control
    input wire logic load,
    input wire logic [7:0] load_val,
    // State
    output logic [7:0] cnt_q,
    output logic last
);

    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_q <= 8'h00;
        end else if (load) begin
            cnt_q <= load_val;
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end

    assign last = (cnt_q == 8'h00);

endmodule

/* File: ams_sequencer.sv */
// Asynchronous memory phase sequencer: setup, strobe, wait, hold, turnaround
// How it works
// - A turnaround gap of the programmed count, but at least one period, follows every access.
// - Without extended wait, a read lasts setup plus strobe plus hold.
// - With extended wait, reads grow until the wait input drops; waiting is counted in sixteen-period units.
// - Read select falls setup periods before strobe, or together in select-strobe mode.
// - Read select rises hold periods after strobe, or together in select-strobe mode.
// - Bank and address are valid the read setup count before strobe falls.
// - Bank and address stay stable the read hold count after strobe rises.
// - Read strobe low for strobe count, extended while the wait input is held.
// - Read strobe rises four periods after the wait input drops.
// - A write lasts setup plus strobe plus hold, plus the wait stretch.
// - Write select falls setup periods before strobe, or together in select-strobe mode.
// - Write select rises hold periods after strobe, or together in select-strobe mode.
// - Write bank and address valid for setup, held for hold periods.
// - Write data valid setup periods before strobe, held hold periods after.
// - Write strobe low for strobe count, extended while the wait input is held.
// - Write strobe rises four periods after the wait input drops.
// - Counted wait units range from one to two hundred fifty-six.
// - Waiting stops with a timeout once the programmed limit is reached.
// - Setup, strobe, hold, turnaround and wait limit counts come from software-written configuration settings.
`timescale 1ns/1ps
`include "ams_consts.svh"
module ams_sequencer (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Configuration
    input wire ams_pkg::ams_cfg_t cfg,
    // Access request
    input wire logic req_valid,
    input wire ams_pkg::ams_req_t req,
    output logic req_ready,
    // Access response
    output logic rsp_valid,
    output ams_pkg::ams_rsp_t rsp,
    // Status
    output logic busy,
    output logic [8:0] waited_cycle_count,
    // Memory pins
    output logic [3:0] mem_chip_select_n,
    output logic mem_read_strobe_n,
    output logic mem_write_strobe_n,
    input wire logic mem_wait_in,
    output logic [1:0] mem_bank_addr,
    output logic [20:0] mem_addr,
    input wire logic [15:0] mem_data_in,
    output logic [15:0] mem_data_out,
    output logic mem_data_oe
);
    import ams_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Phase length helpers: a zero count still gives one period

    function automatic logic [7:0] len_m1(input logic [7:0] n);
        len_m1 = (n == 8'h00) ? 8'h00 : n - 8'h01;
    endfunction

    function automatic logic [7:0] setup_len(input ams_cfg_t c, input logic wr);
        setup_len = len_m1(wr ? {4'h0, c.write_setup_cycles} : {4'h0, c.read_setup_cycles});
    endfunction

    function automatic logic [7:0] strobe_len(input ams_cfg_t c, input logic wr);
        strobe_len = len_m1(wr ? {2'h0, c.write_strobe_cycles}
                               : {2'h0, c.read_strobe_cycles});
    endfunction

    function automatic logic [7:0] hold_len(input ams_cfg_t c, input logic wr);
        hold_len = len_m1(wr ? {5'h00, c.write_hold_cycles} : {5'h00, c.read_hold_cycles});
    endfunction

    localparam logic [7:0] UNIT_M1 = 8'(`AMS_WAIT_UNIT_CYC - 1);
    localparam logic [7:0] REL_M1 = 8'(`AMS_RELEASE_CYC - `AMS_RELEASE_PIPE - 1);

    ////////////////////////////////////////////////////////////////////////
    // State

    ams_state_t state_q;
    ams_state_t state_d;
    ams_cfg_t cfg_q;
    ams_cfg_t cfg_act;
    logic write_q;
    logic wait_q;
    logic wait_seen_q;
    logic [8:0] ewc_q;
    logic timeout_q;
    logic timeout_hit;
    logic accept;
    logic cnt_load;
    logic [7:0] cnt_val;
    logic [7:0] cnt_q;
    logic cnt_last;
    logic wr_act;

    assign accept = req_valid && req_ready;
    // Settings are taken at acceptance so a change mid-access cannot tear it
    assign cfg_act = (state_q == AMS_IDLE) ? cfg : cfg_q;
    assign wr_act = (state_q == AMS_IDLE) ? req.write : write_q;
    // limit field n allows n+1 units, one to 256
    assign timeout_hit = (ewc_q == ({1'b0, cfg_q.max_wait_limit} + 9'h001));

    ams_phase_cnt u_cnt (
        .clk(clk),
        .srst(srst),
        .load(cnt_load),
        .load_val(cnt_val),
        .cnt_q(cnt_q),
        .last(cnt_last)
    );

    ////////////////////////////////////////////////////////////////////////
    // Sequencing

    always_comb begin
        state_d = state_q;
        cnt_load = 1'b0;
        cnt_val = 8'h00;
        unique case (state_q)
            AMS_IDLE: begin
                if (accept) begin
                    state_d = AMS_SETUP;
                    cnt_load = 1'b1;
                    cnt_val = setup_len(cfg, req.write);
                end
            end
            AMS_SETUP: begin
                if (cnt_last) begin
                    state_d = AMS_STROBE;
                    cnt_load = 1'b1;
                    cnt_val = strobe_len(cfg_q, write_q);
                end
            end
            AMS_STROBE: begin
                if (cnt_last) begin
                    cnt_load = 1'b1;
                    if (wait_q || wait_seen_q) begin
                        // strobe stretched while wait holds, counted in units of sixteen
                        state_d = AMS_EXTEND;
                        cnt_val = UNIT_M1;
                    end else begin
                        state_d = AMS_HOLD;
                        cnt_val = hold_len(cfg_q, write_q);
                    end
                end
            end
            AMS_EXTEND: begin
                if (timeout_hit) begin
                    state_d = AMS_HOLD;
                    cnt_load = 1'b1;
                    cnt_val = hold_len(cfg_q, write_q);
                end else if (!wait_q) begin
                    state_d = AMS_RELEASE;
                    cnt_load = 1'b1;
                    cnt_val = REL_M1;
                end else if (cnt_last) begin
                    cnt_load = 1'b1;
                    cnt_val = UNIT_M1;
                end
            end
            AMS_RELEASE: begin
                if (cnt_last) begin
                    state_d = AMS_HOLD;
                    cnt_load = 1'b1;
                    cnt_val = hold_len(cfg_q, write_q);
                end
            end
            AMS_HOLD: begin
                if (cnt_last) begin
                    // idle period is the last gap period
                    // Zero turnaround still leaves one gap: acceptance is registered
                    if (cfg_q.turnaround_cycles <= 2'h1) begin
                        state_d = AMS_IDLE;
                    end else begin
                        state_d = AMS_TURN;
                        cnt_load = 1'b1;
                        cnt_val = {6'h00, cfg_q.turnaround_cycles} - 8'h02;
                    end
                end
            end
            AMS_TURN: begin
                if (cnt_last) begin
                    state_d = AMS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= AMS_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cfg_q <= '0;
            write_q <= 1'b0;
        end else if (accept) begin
            cfg_q <= cfg;
            write_q <= req.write;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wait input and wait unit count

    // wait ignored unless extended wait is on
    always_ff @(posedge clk) begin
        if (srst) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= cfg_act.extended_wait_enable && mem_wait_in;
        end
    end

    // Wait seen any time in the strobe phase, not only at its last period
    always_ff @(posedge clk) begin
        if (srst) begin
            wait_seen_q <= 1'b0;
        end else if (accept) begin
            wait_seen_q <= 1'b0;
        end else if (state_q == AMS_STROBE && wait_q) begin
            wait_seen_q <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ewc_q <= 9'h000;
        end else if (accept) begin
            ewc_q <= 9'h000;
        end else if (state_q == AMS_EXTEND && wait_q && cnt_last && !timeout_hit) begin
            ewc_q <= ewc_q + 9'h001;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            timeout_q <= 1'b0;
        end else if (accept) begin
            timeout_q <= 1'b0;
        end else if (state_q == AMS_EXTEND && timeout_hit) begin
            timeout_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Memory pins, registered from the next state

    logic in_access_d;
    logic strobe_d;
    logic select_d;

    always_comb begin
        in_access_d = (state_d == AMS_SETUP) || (state_d == AMS_STROBE) ||
                      (state_d == AMS_EXTEND) || (state_d == AMS_RELEASE) ||
                      (state_d == AMS_HOLD);
        strobe_d = (state_d == AMS_STROBE) || (state_d == AMS_EXTEND) ||
                   (state_d == AMS_RELEASE);
        // select-strobe mode drops the setup and hold select time
        select_d = cfg_act.select_strobe ? strobe_d : in_access_d;
    end

    logic [1:0] chip_q;

    // select leads and trails the strobe by setup and hold, and falls and rises with it in select-strobe mode
    always_ff @(posedge clk) begin
        if (srst) begin
            mem_chip_select_n <= `AMS_CS_IDLE;
            chip_q <= 2'h0;
        end else begin
            if (accept) begin
                chip_q <= req.chip;
            end
            mem_chip_select_n <= `AMS_CS_IDLE;
            if (select_d) begin
                mem_chip_select_n[accept ? req.chip : chip_q] <= 1'b0;
            end
        end
    end

    // strobes low only in strobe, extend and release
    always_ff @(posedge clk) begin
        if (srst) begin
            mem_read_strobe_n <= 1'b1;
            mem_write_strobe_n <= 1'b1;
        end else begin
            mem_read_strobe_n <= !(strobe_d && !wr_act);
            mem_write_strobe_n <= !(strobe_d && wr_act);
        end
    end

    // address loaded at acceptance, unchanged until the next one
    always_ff @(posedge clk) begin
        if (srst) begin
            mem_addr <= `AMS_ADDR_RST;
            mem_bank_addr <= `AMS_BANK_RST;
        end else if (accept) begin
            mem_addr <= req.addr;
            mem_bank_addr <= req.bank;
        end
    end

    // write data driven from setup through hold
    always_ff @(posedge clk) begin
        if (srst) begin
            mem_data_out <= `AMS_DATA_RST;
            mem_data_oe <= 1'b0;
        end else begin
            if (accept) begin
                mem_data_out <= req.wdata;
            end
            mem_data_oe <= in_access_d && wr_act;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Request and response side

    logic strobe_end;
    assign strobe_end = (state_d == AMS_HOLD) && (state_q != AMS_HOLD);

    always_ff @(posedge clk) begin
        if (srst) begin
            req_ready <= 1'b0;
            busy <= 1'b0;
        end else begin
            req_ready <= (state_d == AMS_IDLE);
            busy <= (state_d != AMS_IDLE);
        end
    end

    // Read data sampled in the last strobe-low period
    always_ff @(posedge clk) begin
        if (srst) begin
            rsp <= '0;
            rsp_valid <= 1'b0;
        end else begin
            rsp_valid <= (state_q == AMS_HOLD) && cnt_last;
            if (strobe_end && !write_q) begin
                rsp.rdata <= mem_data_in;
            end
            if ((state_q == AMS_HOLD) && cnt_last) begin
                rsp.write <= write_q;
                rsp.timeout <= timeout_q;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            waited_cycle_count <= 9'h000;
        end else begin
            waited_cycle_count <= ewc_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    logic [7:0] low_cnt_q;
    logic [3:0] gap_cnt_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            low_cnt_q <= 8'h00;
            gap_cnt_q <= 4'hf;
        end else begin
            low_cnt_q <= (!mem_read_strobe_n || !mem_write_strobe_n) ? low_cnt_q + 8'h01 : 8'h00;
            if (mem_chip_select_n != `AMS_CS_IDLE) begin
                gap_cnt_q <= 4'h0;
            end else if (gap_cnt_q != 4'hf) begin
                gap_cnt_q <= gap_cnt_q + 4'h1;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    chk_turn_gap: assert property (
        $fell(&mem_chip_select_n) |-> gap_cnt_q >= {2'h0, cfg_q.turnaround_cycles})
        else $error("turnaround gap too short");
    chk_read_width: assert property (
        $rose(mem_read_strobe_n) && ewc_q == 9'h000 && !wait_seen_q |->
        low_cnt_q == strobe_len(cfg_q, 1'b0) + 8'h01)
        else $error("read strobe width wrong");
    chk_write_width: assert property (
        $rose(mem_write_strobe_n) && ewc_q == 9'h000 && !wait_seen_q |->
        low_cnt_q == strobe_len(cfg_q, 1'b1) + 8'h01)
        else $error("write strobe width wrong");
    chk_ss_fall: assert property (
        $fell(mem_read_strobe_n) && cfg_q.select_strobe |->
        $past(&mem_chip_select_n) && !(&mem_chip_select_n))
        else $error("select did not fall with strobe");
    chk_select_lead: assert property (
        $fell(mem_write_strobe_n) && !cfg_q.select_strobe |-> $past(!(&mem_chip_select_n)))
        else $error("select did not lead strobe");
    chk_ss_rise: assert property (
        $rose(mem_read_strobe_n) && cfg_q.select_strobe |-> &mem_chip_select_n)
        else $error("select did not rise with strobe");
    chk_addr_hold: assert property (
        $rose(mem_read_strobe_n) |-> $stable(mem_addr) ##1 $stable(mem_bank_addr))
        else $error("address moved at strobe rise");
    chk_data_hold: assert property (
        $rose(mem_write_strobe_n) |-> mem_data_oe && $stable(mem_data_out))
        else $error("write data not held");
    chk_wait_release: assert property (
        state_q == AMS_EXTEND && !wait_q && !timeout_hit |->
        ##2 (!mem_read_strobe_n || !mem_write_strobe_n) ##1
        (mem_read_strobe_n && mem_write_strobe_n))
        else $error("strobe release delay wrong");
    chk_timeout_stop: assert property (
        state_q == AMS_EXTEND && timeout_hit |=> state_q == AMS_HOLD ##[0:255] rsp_valid && rsp.timeout)
        else $error("wait did not time out");
    chk_wait_gate: assert property (
        !cfg_act.extended_wait_enable |=> !wait_q || $past(cfg_act.extended_wait_enable))
        else $error("wait sampled while disabled");

    cov_read: cover property ($rose(mem_read_strobe_n));
    cov_write: cover property ($rose(mem_write_strobe_n));
    cov_extend: cover property (state_q == AMS_EXTEND ##1 state_q == AMS_RELEASE);
    cov_timeout: cover property (rsp_valid && rsp.timeout);

endmodule

/* File: ams_mem_model.sv */
// Behavioural asynchronous memory on the far side of the sequencer pins
`timescale 1ns/1ps
module ams_mem_model (
    // Clock
    input wire logic clk,
    // Memory pins
    input wire logic [3:0] mem_chip_select_n,
    input wire logic mem_read_strobe_n,
    input wire logic mem_write_strobe_n,
    input wire logic [20:0] mem_addr,
    input wire logic [15:0] mem_data_out,
    input wire logic mem_data_oe,
    output logic [15:0] mem_data_in,
    output logic mem_wait_in,
    // Wait length in cycles, zero for a prompt part
    input wire logic [7:0] wait_len
);
    logic [15:0] arr [16];
    logic [15:0] junk_q = 16'h5a5a;
    logic [7:0] cnt_q = 8'h00;
    logic done_q = 1'b0;
    logic sel;
    initial mem_wait_in = 1'b0;
    assign sel = mem_chip_select_n != 4'hf;
    // Released bus moves every cycle so stale data never looks valid
    assign mem_data_in = (sel && !mem_read_strobe_n) ? arr[mem_addr[3:0]] : junk_q;
    always @(posedge clk) begin
        junk_q <= ~junk_q;
        if (sel && !mem_write_strobe_n && mem_data_oe) begin
            arr[mem_addr[3:0]] <= mem_data_out;
        end
    end
    // wait raised early in strobe, held high for wait_len cycles
    always @(posedge clk) begin
        if (!sel) begin
            mem_wait_in <= 1'b0;
            done_q <= 1'b0;
        end else if ((!mem_read_strobe_n || !mem_write_strobe_n) && !done_q && wait_len != 0) begin
            if (!mem_wait_in) begin
                mem_wait_in <= 1'b1;
                cnt_q <= wait_len;
            end else if (cnt_q == 8'h01) begin
                mem_wait_in <= 1'b0;
                done_q <= 1'b1;
            end else begin
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end
endmodule

/* File: test_async_memory_phase_sequencer.sv */
// Self-checking bench for the asynchronous memory phase sequencer
`timescale 1ns/1ps
module test_async_memory_phase_sequencer;
    import ams_pkg::*;
    logic clk, srst, req_valid, req_ready, rsp_valid, busy;
    logic mem_read_strobe_n, mem_write_strobe_n, mem_wait_in, mem_data_oe;
    ams_cfg_t cfg;
    ams_req_t req;
    ams_rsp_t rsp;
    logic [8:0] waited_cycle_count;
    logic [3:0] mem_chip_select_n;
    logic [1:0] mem_bank_addr;
    logic [20:0] mem_addr;
    logic [15:0] mem_data_in, mem_data_out;
    logic [7:0] wait_len;
    logic pins_ok;
    int n_mismatch = 0;
    int total_checks = 0;
    int cs_first, stb_first, n_cs, n_stb, rsp_k, drop_k, rise_k;

    ams_sequencer ams_sequencer_i (.clk(clk), .srst(srst), .cfg(cfg), .req_valid(req_valid),
        .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp), .busy(busy),
        .waited_cycle_count(waited_cycle_count), .mem_chip_select_n(mem_chip_select_n),
        .mem_read_strobe_n(mem_read_strobe_n), .mem_write_strobe_n(mem_write_strobe_n),
        .mem_wait_in(mem_wait_in), .mem_bank_addr(mem_bank_addr), .mem_addr(mem_addr),
        .mem_data_in(mem_data_in), .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe));
    ams_mem_model ams_mem_model_i (.clk(clk), .mem_chip_select_n(mem_chip_select_n),
        .mem_read_strobe_n(mem_read_strobe_n), .mem_write_strobe_n(mem_write_strobe_n),
        .mem_addr(mem_addr), .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe),
        .mem_data_in(mem_data_in), .mem_wait_in(mem_wait_in), .wait_len(wait_len));

    always #4 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////
    task tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task cmp_val(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask

    task cmp_ok(input logic ok, input string what);
        total_checks++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("BAD %0t %s", $time, what);
        end
    endtask

    // every count comes from the settings
    task set_cfg(input logic ss, input logic ew, input logic [1:0] ta, input logic [3:0] s,
                 input logic [5:0] t, input logic [2:0] h, input logic [7:0] lim);
        @(posedge clk);
        cfg <= '{select_strobe:ss, extended_wait_enable:ew, turnaround_cycles:ta,
                 read_setup_cycles:s, read_strobe_cycles:t, read_hold_cycles:h,
                 write_setup_cycles:s, write_strobe_cycles:t, write_hold_cycles:h,
                 max_wait_limit:lim};
    endtask

    // One access; pins sampled just after each edge until the response
    task access(input logic wr, input logic [1:0] ch, input logic [20:0] a, input logic [15:0] d);
        logic [3:0] cs_on;
        logic stb, sp, ws;
        int k;
        cs_on = ~(4'h1 << ch);
        {cs_first, stb_first, n_cs, n_stb, rsp_k, drop_k, rise_k} = '0;
        pins_ok = 1'b1;
        sp = 1'b1;
        ws = 1'b0;
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{write:wr, chip:ch, bank:a[1:0] ^ 2'h3, addr:a, wdata:d};
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (req_ready !== 1'b1 && k < 50);
        req_valid <= 1'b0;
        if (k >= 50) begin
            cmp_ok(1'b0, "request not taken");
            tally_and_finish;
        end
        for (k = 1; k < 400 && rsp_k == 0; k++) begin
            #1;
            stb = wr ? mem_write_strobe_n : mem_read_strobe_n;
            pins_ok &= (wr ? mem_read_strobe_n : mem_write_strobe_n) === 1'b1;
            if (mem_chip_select_n === cs_on) begin
                n_cs++;
                if (cs_first == 0) cs_first = k;
                pins_ok &= mem_addr === a && mem_bank_addr === (a[1:0] ^ 2'h3) && busy === 1'b1;
                pins_ok &= !wr || (mem_data_oe === 1'b1 && mem_data_out === d);
            end else begin
                pins_ok &= mem_chip_select_n === 4'hf;
            end
            if (stb === 1'b0) begin
                n_stb++;
                if (stb_first == 0) stb_first = k;
            end
            if (ws && mem_wait_in === 1'b0 && drop_k == 0) drop_k = k;
            if (!sp && stb === 1'b1 && rise_k == 0) rise_k = k;
            ws = mem_wait_in;
            sp = stb;
            if (rsp_valid === 1'b1) rsp_k = k;
            @(posedge clk);
        end
        if (rsp_k == 0) begin
            cmp_ok(1'b0, "no response");
            tally_and_finish;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Both select modes, nominal and zero setup, strobe and hold counts (zero acts as one)
    task sc_timing;
        int s, t;
        for (int i = 0; i < 4; i++) begin
            set_cfg(i[0], 1'b0, 2'h1, i[1] ? 4'h0 : 4'h2, i[1] ? 6'h00 : 6'h03,
                    i[1] ? 3'h0 : 3'h1, 8'h0f);
            s = i[1] ? 1 : 2;
            t = i[1] ? 1 : 3;
            for (int w = 1; w >= 0; w--) begin
                access(w[0], i[1:0], 21'h1a5a0 + i, 16'hc3a0 + i);
                cmp_val(rsp_k, s + t + 2, "cycle length");
                cmp_val(n_stb, t, "strobe width");
                cmp_val(stb_first, s + 1, "address setup");
                cmp_val(stb_first - cs_first, i[0] ? 0 : s, "select lead");
                cmp_val(n_cs, i[0] ? t : s + t + 1, "select span");
                cmp_ok(pins_ok, "pins during select");
                cmp_val({rsp.write, rsp.timeout}, {w[0], 1'b0}, "response kind");
                if (w == 0) cmp_val(rsp.rdata, 16'hc3a0 + i, "read data");
            end
        end
    endtask

    // Wait ignored while extended wait is off
    task sc_wait_off;
        set_cfg(1'b0, 1'b0, 2'h1, 4'h2, 6'h06, 3'h1, 8'h0f);
        wait_len <= 8'd20;
        access(1'b0, 2'h1, 21'h00003, 16'h0000);
        cmp_val(n_stb, 6, "strobe width wait off");
        cmp_val(rsp_k, 10, "cycle wait off");
    endtask

    // Slow part: strobe stretched, released four cycles after wait drops
    task sc_wait;
        set_cfg(1'b0, 1'b1, 2'h1, 4'h2, 6'h06, 3'h1, 8'h0f);
        wait_len <= 8'd40;
        for (int w = 1; w >= 0; w--) begin
            access(w[0], 2'h2, 21'h00005, 16'h5a0f);
            cmp_val(rise_k - drop_k, 4, "release delay");
            cmp_val(n_stb, 45, "stretched strobe");
            cmp_val(rsp_k, 2 + n_stb + 2, "stretched cycle");
            cmp_ok(waited_cycle_count >= 9'd1 && waited_cycle_count <= 9'd3, "units");
            cmp_val({rsp.timeout, rsp.rdata}, {1'b0, w[0] ? 16'hc3a3 : 16'h5a0f}, "wait rsp");
        end
    endtask

    // Wait held past the limit of one unit
    task sc_timeout;
        set_cfg(1'b0, 1'b1, 2'h1, 4'h2, 6'h06, 3'h1, 8'h00);
        wait_len <= 8'd200;
        access(1'b1, 2'h3, 21'h00007, 16'h0ff0);
        cmp_val(rsp.timeout, 1'b1, "timeout flag");
        cmp_val(waited_cycle_count, 9'd1, "units at limit");
        cmp_ok(n_stb > 6 && n_stb < 40, "strobe cut short");
        wait_len <= 8'd0;
    endtask

    // Requests held back to back: spacing includes the turnaround
    task sc_turn;
        int a1, a2;
        for (int ta = 3; ta >= 0; ta -= 3) begin
            set_cfg(1'b0, 1'b0, ta[1:0], 4'h1, 6'h01, 3'h1, 8'h0f);
            req <= '{write:1'b1, chip:2'h0, bank:2'h1, addr:21'h00009, wdata:16'h1111};
            req_valid <= 1'b1;
            a1 = 0;
            a2 = 0;
            for (int k = 1; k < 60 && a2 == 0; k++) begin
                @(posedge clk);
                if (req_ready === 1'b1) begin
                    if (a1 == 0) a1 = k;
                    else a2 = k;
                end
            end
            req_valid <= 1'b0;
            cmp_val(a2 - a1, (ta == 0) ? 4 : 3 + ta, "access spacing");
            repeat (12) @(posedge clk);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        srst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        cfg = '0;
        wait_len = 8'd0;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        sc_timing;
        sc_wait_off;
        sc_wait;
        sc_timeout;
        sc_turn;
        tally_and_finish;
    end
endmodule
